// file: spi_rate_status_buffers.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module spi_rate_status_buffers (
   input wire logic clk,
   input wire logic nrst,
   input wire spi_rs_pkg::av_req_s av_req,
   output spi_rs_pkg::av_rsp_s av_rsp,
   input wire logic miso,
   input wire logic ste_in_n,
   output spi_rs_pkg::spi_out_s spi_out,
   output logic irq
);
   typedef enum {idle, shift_lo, shift_hi} phase_e;
   typedef struct packed {
      logic [3:0] ctrl;
      logic [15:0] divisor;
      logic loopback;
      logic conflict;
      logic overrun;
      logic [7:0] rx_byte;
      logic [7:0] tx_byte;
      logic tx_full;
      logic [3:0] flags;
      logic [3:0] mask;
      logic [7:0] tx_shift;
      logic [7:0] rx_shift;
      logic [3:0] bit_cnt;
      phase_e phase;
      logic rx_unread;
      logic ack;
      logic [31:0] rdata;
      spi_rs_pkg::spi_out_s pins;
      logic irq;
   } state_s;
   state_s s_q, s_d;
   logic tick;
   logic [1:0] pin_sync;
   logic miso_s, ste_s_n, rx_bit, hold;
   logic rd_hit, wr_hit, wr_done;
   logic [3:0] irq_set;

   function automatic logic [7:0] fit_char(input logic [7:0] v,
                                           input logic seven);
      fit_char = seven ? {1'b0, v[6:0]} : v;
   endfunction

   // -------------------------------------------------------------
   // clocking and pin synchronisers
   // -------------------------------------------------------------
   assign hold = s_q.ctrl[spi_rs_pkg::ctrl_soft_reset_bit];

   spi_rate_gen u_rate (
      .clk(clk),
      .nrst(nrst),
      .hold(hold),
      .bit_clock_divisor(s_q.divisor),
      .tick(tick)
   );

   spi_sync2 u_sync (
      .clk(clk),
      .nrst(nrst),
      .d({miso, ste_in_n}),
      .q(pin_sync)
   );

   assign miso_s = pin_sync[1];
   assign ste_s_n = pin_sync[0];
   assign rx_bit = s_q.loopback ? s_q.pins.mosi : miso_s;
   assign rd_hit = av_req.read && !s_q.ack;
   assign wr_hit = av_req.write && !s_q.ack;
   assign wr_done = av_req.write && s_q.ack;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      irq_set = 4'h0;
      s_d.ack = 1'b0;
      // one wait cycle: answer on the second edge of each request
      if (rd_hit) begin
         s_d.ack = 1'b1;
         s_d.rdata = 32'h00000000;
         if (av_req.address == spi_rs_pkg::ctrl_off) begin
            s_d.rdata[3:0] = s_q.ctrl;
         end else if (av_req.address == spi_rs_pkg::divisor_off) begin
            s_d.rdata[15:0] = s_q.divisor;
         end else if (av_req.address == spi_rs_pkg::status_off) begin
            s_d.rdata[spi_rs_pkg::st_loopback_bit] = s_q.loopback;
            s_d.rdata[spi_rs_pkg::st_conflict_bit] = s_q.conflict;
            s_d.rdata[spi_rs_pkg::st_overrun_bit] = s_q.overrun;
            s_d.rdata[spi_rs_pkg::st_busy_bit] =
               (s_q.phase != idle);
         end else if (av_req.address == spi_rs_pkg::rx_off) begin
            s_d.rdata[7:0] = s_q.rx_byte;
            s_d.overrun = 1'b0;
            s_d.rx_unread = 1'b0;
            s_d.flags[spi_rs_pkg::irq_rx_bit] = 1'b0;
         end else if (av_req.address == spi_rs_pkg::tx_off) begin
            s_d.rdata[7:0] = s_q.tx_byte;
         end else if (av_req.address == spi_rs_pkg::irq_flag_off) begin
            s_d.rdata[3:0] = s_q.flags;
         end else if (av_req.address == spi_rs_pkg::irq_mask_off) begin
            s_d.rdata[3:0] = s_q.mask;
         end
      end
      if (wr_hit) begin
         s_d.ack = 1'b1;
      end
      // a write lands only at the edge that sees waitrequest low
      if (wr_done) begin
         if (av_req.address == spi_rs_pkg::ctrl_off) begin
            s_d.ctrl = av_req.writedata[3:0];
         end else if (av_req.address == spi_rs_pkg::divisor_off) begin
            s_d.divisor = av_req.writedata[15:0];
         end else if (av_req.address == spi_rs_pkg::status_off) begin
            s_d.loopback = av_req.writedata[spi_rs_pkg::st_loopback_bit];
            // overrun is not writable; only zero clears conflict
            if (!av_req.writedata[spi_rs_pkg::st_conflict_bit]) begin
               s_d.conflict = 1'b0;
            end
         end else if (av_req.address == spi_rs_pkg::tx_off) begin
            s_d.tx_byte = fit_char(av_req.writedata[7:0],
               s_q.ctrl[spi_rs_pkg::ctrl_seven_bit]);
            s_d.tx_full = 1'b1;
            s_d.flags[spi_rs_pkg::irq_tx_bit] = 1'b0;
         end else if (av_req.address == spi_rs_pkg::irq_flag_off) begin
            s_d.flags = s_q.flags & ~av_req.writedata[3:0];
         end else if (av_req.address == spi_rs_pkg::irq_mask_off) begin
            s_d.mask = av_req.writedata[3:0];
         end
      end
      // conflict: another master pulls enable low in 4-wire master mode
      if (!hold && s_q.ctrl[spi_rs_pkg::ctrl_master_bit] &&
          s_q.ctrl[spi_rs_pkg::ctrl_four_wire_bit] && !ste_s_n) begin
         s_d.conflict = 1'b1;
         irq_set[spi_rs_pkg::irq_conflict_bit] = 1'b1;
      end
      // -------------------------------------------------------------
      // shift engine, master only
      // -------------------------------------------------------------
      case (s_q.phase)
         idle: begin
            if (!hold && s_q.tx_full && tick &&
                s_q.ctrl[spi_rs_pkg::ctrl_master_bit]) begin
               s_d.tx_shift = s_q.tx_byte;
               s_d.tx_full = 1'b0;
               s_d.bit_cnt = s_q.ctrl[spi_rs_pkg::ctrl_seven_bit] ?
                  spi_rs_pkg::bit_count_seven :
                  spi_rs_pkg::bit_count_full;
               s_d.pins.mosi = s_q.ctrl[spi_rs_pkg::ctrl_seven_bit] ?
                  s_q.tx_byte[6] : s_q.tx_byte[7];
               s_d.pins.ste_n = 1'b0;
               s_d.phase = shift_lo;
            end
         end
         shift_lo: begin
            if (tick) begin
               s_d.pins.sclk = 1'b1;
               s_d.rx_shift = {s_q.rx_shift[6:0], rx_bit};
               s_d.phase = shift_hi;
            end
         end
         shift_hi: begin
            if (tick) begin
               s_d.pins.sclk = 1'b0;
               s_d.bit_cnt = s_q.bit_cnt - 4'h1;
               if (s_q.bit_cnt == 4'h1) begin
                  s_d.rx_byte = fit_char(s_q.rx_shift,
                     s_q.ctrl[spi_rs_pkg::ctrl_seven_bit]);
                  s_d.rx_unread = 1'b1;
                  irq_set[spi_rs_pkg::irq_rx_bit] = 1'b1;
                  if (s_q.rx_unread && !rd_hit) begin
                     s_d.overrun = 1'b1;
                  end
                  if (s_q.rx_unread) begin
                     irq_set[spi_rs_pkg::irq_overrun_bit] = 1'b1;
                  end
                  s_d.pins.ste_n = 1'b1;
                  s_d.phase = idle;
               end else begin
                  s_d.tx_shift = {s_q.tx_shift[6:0], 1'b0};
                  s_d.pins.mosi = s_q.ctrl[spi_rs_pkg::ctrl_seven_bit] ?
                     s_q.tx_shift[5] : s_q.tx_shift[6];
                  s_d.phase = shift_lo;
               end
            end
         end
         default: s_d.phase = idle;
      endcase
      if (!s_q.tx_full || !s_d.tx_full) begin
         irq_set[spi_rs_pkg::irq_tx_bit] = !s_d.tx_full;
      end
      s_d.flags = s_d.flags | irq_set;
      // soft reset holds engine and flags in reset state
      if (hold) begin
         s_d.phase = idle;
         s_d.conflict = 1'b0;
         s_d.overrun = 1'b0;
         s_d.rx_unread = 1'b0;
         s_d.tx_full = 1'b0;
         s_d.flags = spi_rs_pkg::irq_flag_reset;
         s_d.pins = '{sclk: 1'b0, mosi: 1'b0, ste_n: 1'b1};
      end
      s_d.irq = |(s_d.flags & s_d.mask);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.ctrl <= spi_rs_pkg::ctrl_reset;
         s_q.divisor <= spi_rs_pkg::divisor_reset;
         s_q.flags <= spi_rs_pkg::irq_flag_reset;
         s_q.mask <= spi_rs_pkg::irq_mask_reset;
         s_q.phase <= idle;
         s_q.pins.ste_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign av_rsp.readdata = s_q.rdata;
   assign av_rsp.waitrequest = !s_q.ack;
   assign spi_out = s_q.pins;
   assign irq = s_q.irq;
endmodule

// file: spi_rs_pkg.sv
// How it works
// - bit clock is source clock over divisor; zero passes it undivided.
// - loopback enable (bit 7) routes transmitter output into own receiver.
// - conflict flag (bit 6) set on bus conflict in 4-wire master mode only.
// - overrun flag (bit 5) set when a character lands before previous read; a read of any register in that cycle keeps it from being set.
// - reading receive buffer clears overrun; a write to status never clears it.
// - busy bit 0 reads one while a transfer is in progress.
// - receive buffer holds last character in bits 7-0; bits 15-8 read zero.
// - reading receive buffer clears receive error bits and receive-ready flag.
// - in 7-bit mode received character is right-justified, top bit zero.
// - transmit byte is kept until moved into the transmit shift register.
// - writing transmit buffer clears the transmit-empty flag.
// - in 7-bit mode top transmit bit is not sent and is held cleared.
// - while soft reset bit is one the unit logic is held in reset.
// - receive-ready flag is set once a complete character is received.
// - transmit-empty flag set while transmit buffer empty; one after reset.
package spi_rs_pkg;
   // -------------------------------------------------------------
   // register map, byte addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] divisor_off = 8'h04;
   localparam logic [7:0] status_off = 8'h08;
   localparam logic [7:0] rx_off = 8'h0c;
   localparam logic [7:0] tx_off = 8'h10;
   localparam logic [7:0] irq_flag_off = 8'h14;
   localparam logic [7:0] irq_mask_off = 8'h18;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int ctrl_soft_reset_bit = 0;
   localparam int ctrl_master_bit = 1;
   localparam int ctrl_four_wire_bit = 2;
   localparam int ctrl_seven_bit = 3;
   localparam int st_loopback_bit = 7;
   localparam int st_conflict_bit = 6;
   localparam int st_overrun_bit = 5;
   localparam int st_busy_bit = 0;
   localparam int irq_rx_bit = 0;
   localparam int irq_tx_bit = 1;
   localparam int irq_conflict_bit = 2;
   localparam int irq_overrun_bit = 3;
   // -------------------------------------------------------------
   // reset values and frame bit counts
   // -------------------------------------------------------------
   localparam logic [3:0] ctrl_reset = 4'h1;
   localparam logic [15:0] divisor_reset = 16'h0000;
   localparam logic [3:0] irq_flag_reset = 4'h2;
   localparam logic [3:0] irq_mask_reset = 4'h0;
   localparam logic [3:0] bit_count_full = 4'h8;
   localparam logic [3:0] bit_count_seven = 4'h7;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } av_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } av_rsp_s;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic ste_n;
   } spi_out_s;
endpackage

// file: spi_rate_gen.sv
`timescale 1ns/1ns
module spi_rate_gen (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hold,
   input wire logic [15:0] bit_clock_divisor,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } state_s;
   state_s s_q, s_d;
   // -------------------------------------------------------------
   // prescaler: one tick per divisor source cycles
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (hold) begin
         s_d.cnt = 16'h0000;
      end else if (bit_clock_divisor <= 16'h0001) begin
         s_d.tick = 1'b1;
      end else if (s_q.cnt >= bit_clock_divisor - 16'h0001) begin
         s_d.cnt = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;
endmodule

// file: spi_sync2.sv
`timescale 1ns/1ns
module spi_sync2 (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] d,
   output logic [1:0] q
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } state_s;
   state_s s_q, s_d;
   // only s2 is seen outside, s1 may be metastable
   always_comb begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign q = s_q.s2;
endmodule

// file: spi_rs_monitor.sv
`timescale 1ns/1ns
module spi_rs_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire spi_rs_pkg::av_req_s av_req,
   input wire spi_rs_pkg::av_rsp_s av_rsp,
   input wire logic miso,
   input wire logic ste_in_n,
   input wire spi_rs_pkg::spi_out_s spi_out,
   input wire logic irq
);
   // ---------------------
   // snoop and properties
   // ---------------------
   logic ack_w;
   logic ack_r;
   logic srst_q;
   logic seven_q;
   logic [3:0] mask_q;
   logic [15:0] div_q;
   logic [15:0] hi_q;
   logic [7:0] a;
   logic [31:0] wd;
   logic [31:0] rd;
   assign a = av_req.address;
   assign wd = av_req.writedata;
   assign rd = av_rsp.readdata;
   assign ack_w = av_req.write && !av_rsp.waitrequest;
   assign ack_r = av_req.read && !av_rsp.waitrequest;
   // config copies follow bus writes, so they trail by no cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srst_q <= 1'b1;
         seven_q <= 1'b0;
         mask_q <= 4'h0;
         div_q <= 16'h0;
         hi_q <= 16'h0;
      end else begin
         hi_q <= spi_out.sclk ? hi_q + 16'h1 : 16'h0;
         if (ack_w && a == spi_rs_pkg::ctrl_off) begin
            srst_q <= wd[0];
            seven_q <= wd[3];
         end
         if (ack_w && a == spi_rs_pkg::divisor_off) div_q <= wd[15:0];
         if (ack_w && a == spi_rs_pkg::irq_mask_off) mask_q <= wd[3:0];
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence rd_at(logic [7:0] x);
      ack_r && a == x;
   endsequence
   sequence held;
      srst_q && $past(srst_q);
   endsequence
   AST_HALF_BIT: assert property ($fell(spi_out.sclk) |->
      hi_q == ((div_q < 16'h2) ? 16'h1 : div_q)) else $error("sclk width");
   AST_RX_TOP: assert property (rd_at(spi_rs_pkg::rx_off) |->
      rd[31:8] == 24'h0) else $error("rx upper bits");
   AST_ST_RSVD: assert property (rd_at(spi_rs_pkg::status_off) |->
      rd[31:8] == 24'h0 && rd[4:1] == 4'h0) else $error("status reserved");
   AST_RX_SEVEN: assert property (rd_at(spi_rs_pkg::rx_off) |->
      !seven_q || !rd[7]) else $error("rx top bit");
   AST_BUSY: assert property (rd_at(spi_rs_pkg::status_off) |->
      $past(spi_out.ste_n, 2) || $past(spi_out.ste_n) || spi_out.ste_n
      || rd[0]) else $error("busy low in frame");
   AST_HOLD_PINS: assert property (held |->
      spi_out.ste_n && !spi_out.sclk) else $error("pins move in hold");
   AST_HOLD_IDLE: assert property (
      rd_at(spi_rs_pkg::status_off) ##0 held |-> !rd[0])
      else $error("busy in hold");
   AST_RX_CLR: assert property (
      rd_at(spi_rs_pkg::rx_off) ##0 mask_q == 4'h1 |-> ##[1:2] !irq)
      else $error("rx flag kept");
endmodule
bind spi_rate_status_buffers spi_rs_monitor mon (.clk(clk), .nrst(nrst),
   .av_req(av_req), .av_rsp(av_rsp), .miso(miso), .ste_in_n(ste_in_n),
   .spi_out(spi_out), .irq(irq));

// file: spi_far_slave.sv
`timescale 1ns/1ns
module spi_far_slave (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ste_n,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   // ------------
   // far slave
   // ------------
   logic [7:0] sh = 8'h00;
   initial miso = 1'b0;
   initial rx_byte = 8'h00;
   always @(negedge ste_n) begin
      sh = tx_byte;
      miso = sh[7];
   end
   always @(posedge sclk) if (!ste_n) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sclk) if (!ste_n) begin
      sh = sh << 1;
      miso = sh[7];
   end
   // no pull on miso: show the inverse so a late sample is caught
   always @(posedge ste_n) miso = ~miso;
endmodule

// file: spi_rate_status_buffers_test.sv
`timescale 1ns/1ns
module spi_rate_status_buffers_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic miso;
   logic ste_in_n = 1'b1;
   logic irq;
   logic [7:0] far_tx = 8'h00;
   logic [7:0] far_rx;
   logic [7:0] b;
   logic [7:0] b2;
   logic [15:0] dv;
   spi_rs_pkg::av_req_s av_req = '0;
   spi_rs_pkg::av_rsp_s av_rsp;
   spi_rs_pkg::spi_out_s spi_out;
   int n_fail = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   spi_rate_status_buffers uut (.clk(clk), .nrst(nrst), .av_req(av_req),
      .av_rsp(av_rsp), .miso(miso), .ste_in_n(ste_in_n), .spi_out(spi_out),
      .irq(irq));
   spi_far_slave far (.sclk(spi_out.sclk), .mosi(spi_out.mosi),
      .ste_n(spi_out.ste_n), .tx_byte(far_tx), .miso(miso), .rx_byte(far_rx));
   // ---------
   // helpers
   // ---------
   function automatic logic [31:0] rx_exp(input logic [7:0] c, input logic s);
      return {24'h0, s ? {1'b0, c[6:0]} : c};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      av_req <= '{address: a, read: !w, write: w, writedata: d};
      @(posedge clk);
      // no cycle count assumed; only the watchdog ends a stuck wait
      while (av_rsp.waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = av_rsp.readdata;
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wait_irq;
      int n;
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
   endtask
   task automatic wait_ste(input logic v);
      int n;
      for (n = 0; n < 3000 && spi_out.ste_n !== v; n++) @(posedge clk);
      if (n == 3000) n_fail++;
      repeat (3) @(posedge clk);
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(50 * 40000);
      n_fail++;
      conclude;
   end
   initial begin
      void'($urandom(86959));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(spi_rs_pkg::ctrl_off, 32'h1);
      rd(spi_rs_pkg::status_off, 32'h0);
      rd(spi_rs_pkg::irq_flag_off, 32'h2);
      rd(8'h1c, 32'h0);
      $display("reset values done");
      // divisor kept at 4 or more: miso crosses a 2-flop synchroniser
      dv = 16'($urandom % 6 + 4);
      wr(spi_rs_pkg::ctrl_off, 32'h7);
      wr(spi_rs_pkg::divisor_off, {16'h0, dv});
      wr(spi_rs_pkg::irq_mask_off, 32'h1);
      wr(spi_rs_pkg::ctrl_off, 32'h6);
      rd(spi_rs_pkg::divisor_off, {16'h0, dv});
      repeat (4) begin
         b = 8'($urandom);
         far_tx <= 8'($urandom);
         wr(spi_rs_pkg::tx_off, {24'h0, b});
         wait_irq;
         rd(spi_rs_pkg::status_off, 32'h0);
         chk({24'h0, far_rx}, {24'h0, b});
         rd(spi_rs_pkg::rx_off, rx_exp(far_tx, 1'b0));
      end
      $display("random transfers done");
      b = 8'h80;
      b2 = 8'($urandom);
      wr(spi_rs_pkg::tx_off, {24'h0, b});
      wait_ste(1'b0);
      rd(spi_rs_pkg::status_off, 32'h1);
      wr(spi_rs_pkg::tx_off, {24'h0, b2});
      rd(spi_rs_pkg::irq_flag_off, 32'h0);
      wait_irq;
      wait_ste(1'b0);
      wait_ste(1'b1);
      chk({24'h0, far_rx}, {24'h0, b2});
      rd(spi_rs_pkg::status_off, 32'h20);
      rd(spi_rs_pkg::rx_off, rx_exp(far_tx, 1'b0));
      rd(spi_rs_pkg::status_off, 32'h0);
      $display("overrun done");
      ste_in_n <= 1'b0;
      repeat (4) @(posedge clk);
      ste_in_n <= 1'b1;
      rd(spi_rs_pkg::status_off, 32'h40);
      rd(spi_rs_pkg::irq_flag_off, 32'he);
      wr(spi_rs_pkg::irq_mask_off, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(spi_rs_pkg::irq_flag_off, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(spi_rs_pkg::status_off, 32'h40);
      wr(spi_rs_pkg::status_off, 32'h0);
      rd(spi_rs_pkg::status_off, 32'h0);
      wr(spi_rs_pkg::irq_mask_off, 32'h1);
      $display("conflict done");
      wr(spi_rs_pkg::ctrl_off, 32'hb);
      wr(spi_rs_pkg::status_off, 32'h80);
      wr(spi_rs_pkg::divisor_off, 32'h0);
      wr(spi_rs_pkg::ctrl_off, 32'ha);
      rd(spi_rs_pkg::status_off, 32'h80);
      b = 8'($urandom) | 8'h80;
      far_tx <= ~b;
      wr(spi_rs_pkg::tx_off, {24'h0, b});
      wait_irq;
      rd(spi_rs_pkg::rx_off, rx_exp(b, 1'b1));
      chk({25'h0, far_rx[6:0]}, {25'h0, b[6:0]});
      $display("loopback done");
      wr(spi_rs_pkg::ctrl_off, 32'hb);
      wr(spi_rs_pkg::tx_off, 32'h5a);
      repeat (40) @(posedge clk);
      chk({31'h0, spi_out.ste_n}, 32'h1);
      $display("hold done");
      conclude;
   end
endmodule
